// *** logic/pcs_defs.vh ***
// constants for the pll status pin and clock select block
`ifndef PCS_DEFS_VH
`define PCS_DEFS_VH

// ************************************************************
// register addresses
// ************************************************************
`define PCS_ADDR_W          4
`define PCS_REG_PIN_EN      4'h0
`define PCS_REG_POLARITY    4'h1
`define PCS_REG_FORMAT      4'h2
`define PCS_REG_STATUS      4'h3
`define PCS_REG_REF_SEL     4'h4

// ************************************************************
// field layout
// ************************************************************
`define PCS_NCH             4
`define PCS_FMT_W           2
`define PCS_FMT_LVPECL      2'h0
`define PCS_FMT_LVDS        2'h1
`define PCS_FMT_CML         2'h2
`define PCS_FMT_CMOS        2'h3

// ************************************************************
// reset values
// ************************************************************
`define PCS_RST_PIN_EN      4'h0
`define PCS_RST_POLARITY    4'h0
`define PCS_RST_FORMAT      8'h00

`endif

// *** logic/pcs_chan.v ***
// one channel: lock-loss pin, status, reference select, output pair
`timescale 1ns/100ps
`include "pcs_defs.vh"

module pcs_chan (
    input  wire        ref_clk,
    input  wire        nrst,
    input  wire        clk_en,
    input  wire        pin_enable,
    input  wire        polarity,
    input  wire [1:0]  format,
    input  wire        unlocked_sync,
    input  wire        ref_sel_sync,
    input  wire        ext_clk_in,
    input  wire        osc_clk_in,
    output reg         lock_loss_pin_ff,
    output reg         lock_loss_pin_oe_ff,
    output reg         lock_loss_status_ff,
    output reg         ref_sel_ff,
    output reg         out_p_ff,
    output reg         out_n_ff
);

    wire src;

    assign src = ref_sel_sync ? osc_clk_in : ext_clk_in;

    always @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            lock_loss_pin_ff    <= 1'b0;
            lock_loss_pin_oe_ff <= 1'b0;
            lock_loss_status_ff <= 1'b0;
            ref_sel_ff          <= 1'b0;
            out_p_ff            <= 1'b0;
            out_n_ff            <= 1'b0;
        end else if (clk_en) begin
            // status follows lock state whatever the pin setup
            lock_loss_status_ff <= unlocked_sync;
            lock_loss_pin_ff    <= unlocked_sync ^ polarity;
            lock_loss_pin_oe_ff <= pin_enable;
            ref_sel_ff          <= ref_sel_sync;
            out_p_ff            <= src;
            // cmos drives both pins in phase, others differential
            if (format == `PCS_FMT_CMOS) begin
                out_n_ff <= src;
            end else begin
                out_n_ff <= ~src;
            end
        end
    end

endmodule

// *** logic/pcs_top.v ***
// top: register port and four channel instances
// How it works
// - an enabled lock-loss pin is driven high while unlocked and low while locked.
// - a disabled lock-loss pin is released (output enable low).
// - a per-channel polarity bit inverts the driven lock-loss level.
// - a read-only status bit always shows each channel's lock state.
// - the reference-select pin picks the input clock at 0 and the oscillator at 1.
// - register bits pick the output format, differential for pecl, lvds and cml.
// - in cmos format both output pins carry the same in-phase clock.
// - registers are reached through a serial port with a host-driven clock and shared data.
`timescale 1ns/100ps
`include "pcs_defs.vh"

module pcs_top (
    input  wire        ref_clk,
    input  wire        nrst,
    input  wire        clk_en,
    input  wire [3:0]  reg_addr,
    input  wire [7:0]  reg_wdata,
    input  wire        reg_wr,
    input  wire        reg_rd,
    output reg  [7:0]  reg_rdata_ff,
    input  wire [3:0]  pll_unlocked,
    input  wire [3:0]  ref_source_select_pin,
    input  wire [3:0]  external_input_clock,
    input  wire [3:0]  internal_oscillator_ref,
    output wire [3:0]  lock_loss_pin,
    output wire [3:0]  lock_loss_pin_oe,
    output wire [3:0]  ref_source_sel,
    output wire [3:0]  output_clock_pair_p,
    output wire [3:0]  output_clock_pair_n
);

    // ************************************************************
    // registers
    // ************************************************************
    // serial host port sits outside; this is its parallel register side
    //
    // map, one byte per address:
    //   0  lock-loss pin enable, one bit per channel, 1 drives the pin
    //   1  lock-loss polarity, one bit per channel, 1 inverts the pin
    //   2  output format, two bits per channel, channel 0 in the low bits
    //   3  lock-loss status, read only, 1 while that channel is unlocked
    //   4  synced reference select, read only, 1 while on the oscillator
    // any other address drops writes and reads as zero
    //
    // format codes, per channel:
    //   0  pecl-style differential pair
    //   1  lvds-style differential pair
    //   2  cml-style differential pair
    //   3  cmos, both pins in phase
    // only the pin phase lives here; swing and levels belong to the pads
    //
    // reset values:
    //   every pin enable clear, so every lock-loss pin starts released
    //   every polarity clear, so an enabled pin is high while unlocked
    //   every format pecl-style, read data zero
    //
    // timing seen from the register port:
    //   a write lands on the edge that samples its strobe
    //   read data stand in the one cycle after the read strobe
    //   a pin change reaches status and pin three edges later
    //   a source clock reaches its output pair three edges later
    //   clk_en low freezes every flop, the read data included
    //
    // limits:
    //   source clocks are sampled, so a pair follows only clocks that run
    //   well below the reference rate; real clock paths bypass this block
    //   a strap left open reads as whatever the pad settles to, so the
    //   board must hold every strap, high on an unused channel
    //   status shows lock only; it keeps no sticky copy and raises nothing
    //   a read and a write in the same cycle are both taken
    //   unmapped reads still answer, with zero
    reg  [3:0] lock_loss_pin_enable_ff;
    reg  [3:0] lock_loss_polarity_ff;
    reg  [7:0] output_format_select_ff;
    reg  [7:0] nxt_rdata;
    wire [3:0] status;
    wire       wr_pin_en;
    wire       wr_polarity;
    wire       wr_format;
    wire [3:0] wd_pin_en;
    wire [3:0] wd_polarity;
    wire [7:0] wd_format;
    wire [7:0] rd_word_pin_en;
    wire [7:0] rd_word_polarity;
    wire [7:0] rd_word_status;
    wire [7:0] rd_word_ref_sel;

    // ************************************************************
    // write decode
    // ************************************************************
    // the strobe only counts while clk_en runs, so a frozen write is lost
    // rather than held back and applied later
    assign wr_pin_en   = clk_en & reg_wr & (reg_addr == `PCS_REG_PIN_EN);
    assign wr_polarity = clk_en & reg_wr & (reg_addr == `PCS_REG_POLARITY);
    assign wr_format   = clk_en & reg_wr & (reg_addr == `PCS_REG_FORMAT);

    // four-bit registers take the low nibble and ignore the rest
    assign wd_pin_en   = reg_wdata[3:0];
    assign wd_polarity = reg_wdata[3:0];
    assign wd_format   = reg_wdata;

    // ************************************************************
    // control registers
    // ************************************************************
    // one flop group per register keeps each write path easy to follow;
    // status and select have no write path, so writes to them fall away
    always @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            lock_loss_pin_enable_ff <= `PCS_RST_PIN_EN;
        end else if (wr_pin_en) begin
            lock_loss_pin_enable_ff <= wd_pin_en;
        end
    end

    always @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            lock_loss_polarity_ff <= `PCS_RST_POLARITY;
        end else if (wr_polarity) begin
            lock_loss_polarity_ff <= wd_polarity;
        end
    end

    always @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            output_format_select_ff <= `PCS_RST_FORMAT;
        end else if (wr_format) begin
            output_format_select_ff <= wd_format;
        end
    end

    // ************************************************************
    // read port
    // ************************************************************
    // four-bit registers read back with zero upper bits
    assign rd_word_pin_en   = {4'h0, lock_loss_pin_enable_ff};
    assign rd_word_polarity = {4'h0, lock_loss_polarity_ff};
    assign rd_word_status   = {4'h0, status};
    assign rd_word_ref_sel  = {4'h0, ref_source_sel};

    // pure selection: reading status never disturbs it
    always @* begin
        case (reg_addr)
            `PCS_REG_PIN_EN: begin
                nxt_rdata = rd_word_pin_en;
            end
            `PCS_REG_POLARITY: begin
                nxt_rdata = rd_word_polarity;
            end
            `PCS_REG_FORMAT: begin
                nxt_rdata = output_format_select_ff;
            end
            `PCS_REG_STATUS: begin
                nxt_rdata = rd_word_status;
            end
            `PCS_REG_REF_SEL: begin
                nxt_rdata = rd_word_ref_sel;
            end
            default: begin
                nxt_rdata = 8'h00;
            end
        endcase
    end

    // zero outside the answer cycle, so a stale word is never seen twice
    // and a host that samples late reads zero rather than old data
    always @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            reg_rdata_ff <= 8'h00;
        end else if (clk_en) begin
            if (reg_rd) begin
                reg_rdata_ff <= nxt_rdata;
            end else begin
                reg_rdata_ff <= 8'h00;
            end
        end
    end

    // ************************************************************
    // channels
    // ************************************************************
    // one generate pass per channel: its own synchronisers, control bits
    // and channel instance; only the register vectors are shared
    // the channel module owns the output flops, so every top output
    // still comes straight from a flop
    genvar i;
    generate
        for (i = 0; i < `PCS_NCH; i = i + 1) begin : g_ch
            reg        unl_s1_ff;
            reg        unl_s2_ff;
            reg        sel_s1_ff;
            reg        sel_s2_ff;
            reg        ext_s1_ff;
            reg        ext_s2_ff;
            reg        osc_s1_ff;
            reg        osc_s2_ff;
            wire [1:0] ch_format;
            wire       ch_enable;
            wire       ch_polarity;

            assign ch_format   = output_format_select_ff[2*i+1:2*i];
            assign ch_enable   = lock_loss_pin_enable_ff[i];
            assign ch_polarity = lock_loss_polarity_ff[i];

            // lock state from the pll side: first stage samples the pin
            always @(posedge ref_clk or negedge nrst) begin
                if (!nrst) begin
                    unl_s1_ff <= 1'b0;
                end else if (clk_en) begin
                    unl_s1_ff <= pll_unlocked[i];
                end
            end

            // second stage is the only reader of the first
            always @(posedge ref_clk or negedge nrst) begin
                if (!nrst) begin
                    unl_s2_ff <= 1'b0;
                end else if (clk_en) begin
                    unl_s2_ff <= unl_s1_ff;
                end
            end

            // board strap: first stage
            always @(posedge ref_clk or negedge nrst) begin
                if (!nrst) begin
                    sel_s1_ff <= 1'b0;
                end else if (clk_en) begin
                    sel_s1_ff <= ref_source_select_pin[i];
                end
            end

            // board strap: second stage, read by the channel only
            always @(posedge ref_clk or negedge nrst) begin
                if (!nrst) begin
                    sel_s2_ff <= 1'b0;
                end else if (clk_en) begin
                    sel_s2_ff <= sel_s1_ff;
                end
            end

            // external input clock, sampled as a level
            always @(posedge ref_clk or negedge nrst) begin
                if (!nrst) begin
                    ext_s1_ff <= 1'b0;
                end else if (clk_en) begin
                    ext_s1_ff <= external_input_clock[i];
                end
            end

            // external input clock, second stage
            always @(posedge ref_clk or negedge nrst) begin
                if (!nrst) begin
                    ext_s2_ff <= 1'b0;
                end else if (clk_en) begin
                    ext_s2_ff <= ext_s1_ff;
                end
            end

            // oscillator clock, sampled the same way so both paths match
            always @(posedge ref_clk or negedge nrst) begin
                if (!nrst) begin
                    osc_s1_ff <= 1'b0;
                end else if (clk_en) begin
                    osc_s1_ff <= internal_oscillator_ref[i];
                end
            end

            // oscillator clock, second stage
            always @(posedge ref_clk or negedge nrst) begin
                if (!nrst) begin
                    osc_s2_ff <= 1'b0;
                end else if (clk_en) begin
                    osc_s2_ff <= osc_s1_ff;
                end
            end

            pcs_chan u_chan (
                .ref_clk             (ref_clk),
                .nrst                (nrst),
                .clk_en              (clk_en),
                .pin_enable          (ch_enable),
                .polarity            (ch_polarity),
                .format              (ch_format),
                .unlocked_sync       (unl_s2_ff),
                .ref_sel_sync        (sel_s2_ff),
                .ext_clk_in          (ext_s2_ff),
                .osc_clk_in          (osc_s2_ff),
                .lock_loss_pin_ff    (lock_loss_pin[i]),
                .lock_loss_pin_oe_ff (lock_loss_pin_oe[i]),
                .lock_loss_status_ff (status[i]),
                .ref_sel_ff          (ref_source_sel[i]),
                .out_p_ff            (output_clock_pair_p[i]),
                .out_n_ff            (output_clock_pair_n[i])
            );
        end
    endgenerate

endmodule

// *** testbench/pcs_monitor.sv ***
// checker for the pll status pin and clock select block
`timescale 1ns/100ps
module pcs_monitor (
    input wire       ref_clk, nrst, clk_en, reg_wr, reg_rd,
    input wire [3:0] reg_addr, pll_unlocked, ref_source_select_pin, external_input_clock,
    input wire [3:0] internal_oscillator_ref, lock_loss_pin, lock_loss_pin_oe, ref_source_sel,
    input wire [3:0] output_clock_pair_p, output_clock_pair_n,
    input wire [7:0] reg_wdata, reg_rdata_ff
);
    reg  [3:0] en_ff, pol_ff;
    reg  [7:0] fmt_ff;
    wire [3:0] cm = {fmt_ff[7:6] == 2'h3, fmt_ff[5:4] == 2'h3, fmt_ff[3:2] == 2'h3,
                     fmt_ff[1:0] == 2'h3};
    wire [3:0] src = (ref_source_sel & internal_oscillator_ref)
                   | (~ref_source_sel & external_input_clock);
    wire       wr = clk_en & reg_wr;
    // shadow copies of the writable controls
    always @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            en_ff <= 4'h0;
            pol_ff <= 4'h0;
            fmt_ff <= 8'h00;
        end else begin
            if (wr && reg_addr == 4'h0) en_ff <= reg_wdata[3:0];
            if (wr && reg_addr == 4'h1) pol_ff <= reg_wdata[3:0];
            if (wr && reg_addr == 4'h2) fmt_ff <= reg_wdata;
        end
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    a_pin_drive_enable: assert property ((clk_en && $stable(en_ff)) [*3] |-> lock_loss_pin_oe == en_ff)
        else $error("lock pin enable wrong");
    a_pin_lock_level: assert property ((clk_en && $stable(pll_unlocked) && $stable(pol_ff)) [*4]
        |-> (lock_loss_pin & en_ff) == ((pll_unlocked ^ pol_ff) & en_ff))
        else $error("lock pin level wrong");
    a_status_read: assert property ((clk_en && $stable(pll_unlocked)) [*5] ##0 (reg_rd && reg_addr == 4'h3)
        |=> reg_rdata_ff == {4'h0, pll_unlocked})
        else $error("status read wrong");
    a_ref_select: assert property ((clk_en && $stable(ref_source_select_pin)) [*4]
        |-> ref_source_sel == ref_source_select_pin)
        else $error("reference select wrong");
    a_source_route: assert property ((clk_en && $stable(src) && $stable(ref_source_sel)) [*6]
        |-> output_clock_pair_p == src)
        else $error("output source wrong");
    a_pair_format: assert property ((clk_en && $stable(fmt_ff)) [*3]
        |-> output_clock_pair_n == (output_clock_pair_p ^ ~cm))
        else $error("output pair format wrong");
    a_read_idle: assert property (!(clk_en && reg_rd && reg_addr <= 4'h4) |=> reg_rdata_ff == 8'h00)
        else $error("idle read data not zero");
    a_enable_readback: assert property (clk_en && reg_rd && reg_addr == 4'h0
        |=> reg_rdata_ff == {4'h0, $past(en_ff)})
        else $error("enable readback wrong");
endmodule
bind pcs_top pcs_monitor pcs_monitor_inst (.*);

// *** testbench/pcs_partner.sv ***
// board side: source clocks and reference straps
`timescale 1ns/100ps
module pcs_partner (
    input  wire       ref_clk,
    input  wire [3:0] strap,
    output wire [3:0] ref_source_select_pin,
    output wire [3:0] external_input_clock,
    output wire [3:0] internal_oscillator_ref
);
    reg [6:0] cnt_ff = 7'h00;
    always @(posedge ref_clk) cnt_ff <= cnt_ff + 7'h01;
    // slow edges so sampled levels settle between changes
    assign external_input_clock = cnt_ff[6:3];
    assign internal_oscillator_ref = ~cnt_ff[6:3] ^ 4'h5;
    assign ref_source_select_pin = strap;
endmodule

// *** testbench/pcs_top_tb.sv ***
// self-checking bench for the pll status pin and clock select block
`timescale 1ns/100ps
module pcs_top_tb;
    reg        ref_clk = 0, nrst = 0, clk_en = 1, reg_wr = 0, reg_rd = 0;
    reg  [3:0] reg_addr = 0, pll_unlocked = 0, strap = 4'hf, en, pol;
    reg  [7:0] reg_wdata = 0, lfsr = 8'h4c, seen, fmt;
    wire [7:0] reg_rdata_ff;
    wire [3:0] ref_source_select_pin, external_input_clock, internal_oscillator_ref;
    wire [3:0] lock_loss_pin, lock_loss_pin_oe, ref_source_sel;
    wire [3:0] output_clock_pair_p, output_clock_pair_n;
    integer    miscompares = 0, checks_done = 0, cycles = 0, i;
    pcs_top pcs_top_inst (.*);
    pcs_partner pcs_partner_inst (.*);
    initial forever #12.5 ref_clk = ~ref_clk;
    function [7:0] nx(input [7:0] s);
        nx = {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    function [3:0] cm(input [7:0] f);
        cm = {f[7:6] == 2'h3, f[5:4] == 2'h3, f[3:2] == 2'h3, f[1:0] == 2'h3};
    endfunction
    task check(input [7:0] got, input [7:0] exp);
        begin
            checks_done = checks_done + 1;
            if (got !== exp) begin
                miscompares = miscompares + 1;
                $display("wrong value at %0t: seen %h expected %h", $time, got, exp);
            end
        end
    endtask
    task wr(input [3:0] a, input [7:0] d);
        begin
            @(posedge ref_clk) {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
            @(posedge ref_clk) reg_wr <= 1'b0;
        end
    endtask
    task rd(input [3:0] a);
        begin
            @(posedge ref_clk) {reg_rd, reg_addr} <= {1'b1, a};
            @(posedge ref_clk) reg_rd <= 1'b0;
            #1 seen = reg_rdata_ff;
        end
    endtask
    task summarize;
        begin
            $display("checks %0d mismatches %0d", checks_done, miscompares);
            if (miscompares == 0 && checks_done > 0) $display("[ PASS ]");
            else $display("[ FAIL ]");
            $finish;
        end
    endtask
    always @(posedge ref_clk) begin
        cycles = cycles + 1;
        if (cycles == 5000) begin
            miscompares = miscompares + 1;
            summarize;
        end
    end
    initial begin
        repeat (20) @(posedge ref_clk);
        nrst <= 1'b1;
        for (i = 0; i < 40; i = i + 1) begin
            lfsr = nx(lfsr);
            {pol, en} = lfsr;
            lfsr = nx(lfsr);
            // first passes set every output format code on all channels
            fmt = (i < 4) ? {4{i[1:0]}} : lfsr;
            wr(4'h0, {4'h0, en});
            wr(4'h1, {4'h0, pol});
            wr(4'h2, fmt);
            lfsr = nx(lfsr);
            {strap, pll_unlocked} <= lfsr;
            repeat (6) @(posedge ref_clk);
            #1;
            check({4'h0, lock_loss_pin_oe}, {4'h0, en});
            check({4'h0, lock_loss_pin & en}, {4'h0, (pll_unlocked ^ pol) & en});
            check({4'h0, ref_source_sel}, {4'h0, strap});
            check({4'h0, output_clock_pair_n}, {4'h0, output_clock_pair_p ^ ~cm(fmt)});
            rd(4'h3);
            check(seen, {4'h0, pll_unlocked});
            rd(4'h2);
            check(seen, fmt);
            rd(4'h8 | lfsr[2:0]);
            check(seen, 8'h00);
        end
        // a write while frozen must not land
        @(posedge ref_clk) clk_en <= 1'b0;
        wr(4'h0, {4'h0, ~en});
        clk_en <= 1'b1;
        rd(4'h0);
        check(seen, {4'h0, en});
        summarize;
    end
endmodule
